/* File: hw/gdfsb_params.svh */
// Purpose: Offsets, field positions, reset values and counts of the
//          gate driver fault status bank.
// Assumes: Eight-bit registers addressed by a six-bit offset.
// Notes:   Definitions only.
`ifndef GDFSB_PARAMS_SVH
`define GDFSB_PARAMS_SVH

`define GDFSB_OFF_GLOBAL      6'h00
`define GDFSB_OFF_DS_LOW      6'h01
`define GDFSB_OFF_DS_HIGH     6'h02
`define GDFSB_OFF_GATE_LOW    6'h03
`define GDFSB_OFF_GATE_HIGH   6'h04
`define GDFSB_OFF_SUPPLY      6'h05
`define GDFSB_OFF_VARIANT     6'h06

`define GDFSB_RST_GLOBAL      8'hc0
`define GDFSB_RST_FLAGS       8'h00
`define GDFSB_RST_VARIANT_HI  4'h0

`define GDFSB_BIT_LINK_OK     7
`define GDFSB_BIT_POWER_ON    6
`define GDFSB_BIT_FAULT       5
`define GDFSB_BIT_WARN        4
`define GDFSB_BIT_TRANSISTOR_FAULT_SUMMARY       3
`define GDFSB_BIT_LOW_SUPPLY  2
`define GDFSB_BIT_HIGH_SUPPLY 1
`define GDFSB_BIT_THERMAL     0

`define GDFSB_FRAME_BITS      5'd16
`define GDFSB_BYTE_LAST       5'd7
`define GDFSB_CNT_MAX         5'd31

`endif

/* File: hw/gdfsb_pkg.sv */
// Purpose: Types shared by the gate driver fault status bank.
// Assumes: Flags arrive already summarised per kind.
// Notes:   Numbers live in gdfsb_params.svh.
package gdfsb_pkg;

    typedef struct packed {
        logic csN;
        logic sclk;
        logic sdi;
    } gdfsb_spi_t;

    typedef struct packed {
        logic pvddUv;
        logic pvddOv;
        logic vcpUv;
        logic thermalWarningFlag;
        logic thermalShutdownFlag;
        logic watchdogTimeoutFlag;
    } gdfsb_supply_t;

    typedef struct packed {
        logic currentDirectionWarning;
        logic prechargeWarning;
        logic predischargeWarning;
        logic slewTimeWarning;
    } gdfsb_warn_t;

endpackage

/* File: hw/gdfsb_sync.sv */
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to mclk.
// Notes:   Only the second stage may be read outside.
`timescale 1ns/1ps
module gdfsb_sync #(
    parameter int          WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_r <= RESET_VAL;
            dout     <= RESET_VAL;
        end else begin
            stage1_r <= din;
            dout     <= stage1_r;
        end
    end
endmodule

/* File: hw/gdfsb_status_bank.sv */
// Purpose: Read-only fault status bank of an eight-channel gate driver,
//          read by a controller over a 16-clock serial frame.
// Assumes: Fault flags come from logic on mclk; serial pins are async.
// Notes:   Reply is the global register, then the addressed register.
// Summary of operation
// - Offsets 0 to 6 decode to the seven status registers.
// - Global register leaves reset at c0.
// - Bit 7 is one until a frame clock count error occurs.
// - Bit 6 is set after power-on reset, else zero.
// - Bit 5 always mirrors the fault interrupt pin state.
// - Bits 4, 2, 1 flag warning, undervoltage, overvoltage; reset zero.
// - Bit 3 is the OR of all overcurrent and gate flags.
// - Bit 0 ORs thermal, watchdog and gate-drive warning flags.
// - Offset 1 holds bridge 1-4 overcurrent pairs, high side first.
// - Offset 2 holds bridge 5-8 overcurrent pairs, high side first.
// - Each overcurrent flag is one while that transistor is faulted.
// - A frame without exactly 16 clocks sets an error, not the pin.
`timescale 1ns/1ps
`include "gdfsb_params.svh"
module gdfsb_status_bank #(
    // Value is arbitrary.
    parameter logic [3:0] VARIANT_ID = 4'h3
) (
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    input  wire gdfsb_pkg::gdfsb_spi_t   spiIn,
    input  wire logic [15:0]             overcurrentFlags,
    input  wire logic [15:0]             gateFlags,
    input  wire gdfsb_pkg::gdfsb_supply_t supplyFlags,
    input  wire gdfsb_pkg::gdfsb_warn_t  warnFlags,
    input  wire logic                    clearFaults,
    output logic                         sdo,
    output logic                         sdoOe_n,
    output logic                         faultInterruptPin_n
);
    import gdfsb_pkg::*;

    gdfsb_spi_t spiS;
    gdfsb_sync #(
        .WIDTH     (3),
        .RESET_VAL (3'h4)
    ) u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .din   (spiIn),
        .dout  (spiS)
    );

    // Status group.
    logic [7:0] globalReg_r, globalReg_nxt;
    logic [7:0] dsLow_r, dsHigh_r, gateLow_r, gateHigh_r, supplyReg_r;
    logic       frameErr_r, frameErr_nxt;
    logic       por_r, por_nxt;
    logic       pin_n_nxt;
    logic       dsGs, lowSupply, highSupply, thermalSum, warnSum, faultSum;

    // Serial group.
    logic       prevCs_r, prevSclk_r;
    logic [4:0] bitCnt_r, bitCnt_nxt;
    logic [7:0] rxShift_r, rxShift_nxt;
    logic [7:0] txSnap_r, txSnap_nxt;
    logic [7:0] rdData_r, rdData_nxt;
    logic       sdo_nxt, sdoOe_n_nxt;
    logic       csFall, csRise, sclkFall, sclkRise, active, byteDone;
    logic [7:0] readMux;

    always_comb begin
        dsGs       = |{overcurrentFlags, gateFlags};
        lowSupply  = supplyFlags.pvddUv | supplyFlags.vcpUv;
        highSupply = supplyFlags.pvddOv;
        thermalSum = supplyFlags.thermalWarningFlag
                   | supplyFlags.thermalShutdownFlag
                   | supplyFlags.watchdogTimeoutFlag
                   | (|warnFlags);
        warnSum    = supplyFlags.thermalWarningFlag | (|warnFlags);
        // Frame errors stay off the pin so a noisy bus cannot trip it.
        faultSum   = dsGs | lowSupply | highSupply
                   | supplyFlags.thermalShutdownFlag
                   | supplyFlags.watchdogTimeoutFlag;
        pin_n_nxt  = ~faultSum;
        // A new error in the clearing cycle wins over the clear.
        if (csRise && bitCnt_r != `GDFSB_FRAME_BITS) begin
            frameErr_nxt = 1'b1;
        end else if (clearFaults) begin
            frameErr_nxt = 1'b0;
        end else begin
            frameErr_nxt = frameErr_r;
        end
        por_nxt = clearFaults ? 1'b0 : por_r;
        globalReg_nxt = {~frameErr_nxt, por_nxt, faultSum,
                         warnSum, dsGs, lowSupply, highSupply,
                         thermalSum};
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            globalReg_r         <= `GDFSB_RST_GLOBAL;
            dsLow_r             <= `GDFSB_RST_FLAGS;
            dsHigh_r            <= `GDFSB_RST_FLAGS;
            gateLow_r           <= `GDFSB_RST_FLAGS;
            gateHigh_r          <= `GDFSB_RST_FLAGS;
            supplyReg_r         <= `GDFSB_RST_FLAGS;
            frameErr_r          <= 1'b0;
            por_r               <= 1'b1;
            faultInterruptPin_n <= 1'b1;
        end else begin
            globalReg_r         <= globalReg_nxt;
            dsLow_r             <= overcurrentFlags[15:8];
            dsHigh_r            <= overcurrentFlags[7:0];
            gateLow_r           <= gateFlags[15:8];
            gateHigh_r          <= gateFlags[7:0];
            supplyReg_r         <= {supplyFlags, frameErr_nxt, 1'b0};
            frameErr_r          <= frameErr_nxt;
            por_r               <= por_nxt;
            faultInterruptPin_n <= pin_n_nxt;
        end
    end

    // Reads only; the frame's write flag and data byte are discarded.
    // The offset is formed from the shift register and the incoming bit,
    // so the mux does not depend on the serial next-state process.
    always_comb begin
        unique case ({rxShift_r[4:0], spiS.sdi})
            `GDFSB_OFF_GLOBAL:    readMux = globalReg_r;
            `GDFSB_OFF_DS_LOW:    readMux = dsLow_r;
            `GDFSB_OFF_DS_HIGH:   readMux = dsHigh_r;
            `GDFSB_OFF_GATE_LOW:  readMux = gateLow_r;
            `GDFSB_OFF_GATE_HIGH: readMux = gateHigh_r;
            `GDFSB_OFF_SUPPLY:    readMux = supplyReg_r;
            `GDFSB_OFF_VARIANT:   readMux = {`GDFSB_RST_VARIANT_HI,
                                             VARIANT_ID};
            default:              readMux = 8'h00;
        endcase
    end

    always_comb begin
        csFall   = prevCs_r && !spiS.csN;
        csRise   = !prevCs_r && spiS.csN;
        active   = !spiS.csN;
        sclkFall = active && prevSclk_r && !spiS.sclk;
        sclkRise = active && !prevSclk_r && spiS.sclk;
        byteDone = sclkFall && bitCnt_r == `GDFSB_BYTE_LAST;
        bitCnt_nxt  = bitCnt_r;
        rxShift_nxt = rxShift_r;
        txSnap_nxt  = txSnap_r;
        rdData_nxt  = rdData_r;
        sdo_nxt     = sdo;
        sdoOe_n_nxt = sdoOe_n;
        if (csFall) begin
            bitCnt_nxt  = 5'd0;
            txSnap_nxt  = globalReg_r;
            sdo_nxt     = globalReg_r[7];
            sdoOe_n_nxt = 1'b0;
        end else if (csRise) begin
            sdoOe_n_nxt = 1'b1;
        end
        if (sclkFall) begin
            rxShift_nxt = {rxShift_r[6:0], spiS.sdi};
            if (bitCnt_r != `GDFSB_CNT_MAX) begin
                bitCnt_nxt = bitCnt_r + 5'd1;
            end
        end
        if (byteDone) begin
            rdData_nxt = readMux;
        end
        if (sclkRise) begin
            if (bitCnt_r < 5'd8) begin
                sdo_nxt = txSnap_r[~bitCnt_r[2:0]];
            end else if (bitCnt_r < `GDFSB_FRAME_BITS) begin
                sdo_nxt = rdData_r[~bitCnt_r[2:0]];
            end else begin
                sdo_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prevCs_r   <= 1'b1;
            prevSclk_r <= 1'b0;
            bitCnt_r   <= 5'd0;
            rxShift_r  <= 8'h00;
            txSnap_r   <= 8'h00;
            rdData_r   <= 8'h00;
            sdo        <= 1'b0;
            sdoOe_n    <= 1'b1;
        end else begin
            prevCs_r   <= spiS.csN;
            prevSclk_r <= spiS.sclk;
            bitCnt_r   <= bitCnt_nxt;
            rxShift_r  <= rxShift_nxt;
            txSnap_r   <= txSnap_nxt;
            rdData_r   <= rdData_nxt;
            sdo        <= sdo_nxt;
            sdoOe_n    <= sdoOe_n_nxt;
        end
    end

    property p_globalReset;
        @(posedge mclk) $rose(rst_n) |-> globalReg_r == 8'hc0;
    endproperty
    a_globalReset: assert property (p_globalReset)
        else $error("global register not c0 after reset");

    property p_linkOk;
        @(posedge mclk) disable iff (!rst_n)
        (csRise && bitCnt_r != 5'd16) |=> !globalReg_r[7] && supplyReg_r[1];
    endproperty
    a_linkOk: assert property (p_linkOk)
        else $error("frame count error not flagged");

    property p_powerOn;
        @(posedge mclk) disable iff (!rst_n)
        $fell(globalReg_r[6]) |-> $past(clearFaults);
    endproperty
    a_powerOn: assert property (p_powerOn)
        else $error("power-on bit cleared without request");

    property p_pinMirror;
        @(posedge mclk) disable iff (!rst_n)
        globalReg_r[5] == !faultInterruptPin_n;
    endproperty
    a_pinMirror: assert property (p_pinMirror)
        else $error("fault bit differs from pin");

    property p_summary;
        @(posedge mclk) disable iff (!rst_n)
        ##1 globalReg_r[2:1] == {$past(supplyFlags.pvddUv | supplyFlags.vcpUv),
                                 $past(supplyFlags.pvddOv)};
    endproperty
    a_summary: assert property (p_summary)
        else $error("supply summary bits wrong");

    property p_dsGs;
        @(posedge mclk) disable iff (!rst_n)
        ##1 globalReg_r[3] == $past(|{overcurrentFlags, gateFlags})
            && globalReg_r[5] == !faultInterruptPin_n;
    endproperty
    a_dsGs: assert property (p_dsGs)
        else $error("transistor summary bit not set");

    property p_thermal;
        @(posedge mclk) disable iff (!rst_n)
        (warnFlags != 4'h0) |=> globalReg_r[0] && globalReg_r[4];
    endproperty
    a_thermal: assert property (p_thermal)
        else $error("warning summary bit not set");

    property p_dsMap;
        @(posedge mclk) disable iff (!rst_n)
        ##1 {dsLow_r, dsHigh_r} == $past(overcurrentFlags);
    endproperty
    a_dsMap: assert property (p_dsMap)
        else $error("overcurrent bit mapping wrong");

    property p_noPinOnFrameErr;
        @(posedge mclk) disable iff (!rst_n)
        ##1 faultInterruptPin_n == !$past(dsGs | lowSupply | highSupply
            | supplyFlags.thermalShutdownFlag
            | supplyFlags.watchdogTimeoutFlag);
    endproperty
    a_noPinOnFrameErr: assert property (p_noPinOnFrameErr)
        else $error("pin does not follow fault causes");

    property p_readDs;
        @(posedge mclk) disable iff (!rst_n)
        (byteDone && rxShift_nxt[5:0] == 6'h01) |=> rdData_r == $past(dsLow_r);
    endproperty
    a_readDs: assert property (p_readDs)
        else $error("offset 1 read returned wrong data");
endmodule

/* File: sim/gdfsb_spi_ctrl.sv */
// Purpose: Serial controller model that runs frames on the status bank.
// Assumes: Each serial clock phase lasts five mclk periods.
// Notes:   Reply bits are taken late in each high phase, before the fall.
`timescale 1ns/1ps
module gdfsb_spi_ctrl (
    input  wire logic           mclk,
    input  wire logic           sdo,
    input  wire logic           sdoOe_n,
    output gdfsb_pkg::gdfsb_spi_t spiOut
);
    import gdfsb_pkg::*;
    logic sdoLast;
    logic sdoWire;

    initial spiOut = '{csN: 1'b1, sclk: 1'b0, sdi: 1'b0};
    always @(posedge mclk) if (!sdoOe_n) sdoLast <= sdo;
    // A released reply line floats, so stale data must not read as valid.
    assign sdoWire = sdoOe_n ? ~sdoLast : sdo;

    task automatic wait_mclk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic frame(input logic [15:0] cmdIn, input int nClk,
                         output logic [15:0] rsp);
        logic [15:0] cmd;
        cmd = cmdIn;
        if (cmd[15] && cmd[13:8] > 6'h06) begin
            cmd[15] = 1'b0;
        end
        rsp = 16'h0000;
        wait_mclk(1);
        spiOut.csN = 1'b0;
        for (int i = 0; i < nClk; i++) begin
            // Data moves mid low phase, away from the sampling fall.
            wait_mclk(2);
            spiOut.sdi = cmd[15 - (i % 16)];
            wait_mclk(3);
            spiOut.sclk = 1'b1;
            // The bank launches each bit on the rise, three cycles late.
            wait_mclk(5);
            rsp = {rsp[14:0], sdoWire};
            spiOut.sclk = 1'b0;
        end
        wait_mclk(5);
        spiOut.csN = 1'b1;
        spiOut.sdi = ~spiOut.sdi;
        wait_mclk(8);
    endtask
endmodule

/* File: sim/tb.sv */
// Purpose: Self-checking bench for the fault status bank.
// Assumes: Inputs change one ns after the rising mclk edge.
// Notes:   Expected values come from the flag inputs held by the bench.
`timescale 1ns/1ps
`include "gdfsb_params.svh"
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
    nFail++; $display("unexpected %s: expected %h seen %h", nm, exp, got); \
    end end
module tb;
    import gdfsb_pkg::*;
    // Value is arbitrary.
    localparam logic [3:0] VARIANT = 4'h5;
    logic          mclk = 1'b0;
    logic          rst_n = 1'b0;
    gdfsb_spi_t    spi;
    logic [15:0]   overcurrentFlags = 16'h0000;
    logic [15:0]   gateFlags = 16'h0000;
    gdfsb_supply_t supplyFlags = '0;
    gdfsb_warn_t   warnFlags = '0;
    logic          clearFaults = 1'b0;
    logic          sdo;
    logic          sdoOe_n;
    logic          faultInterruptPin_n;
    logic          linkOk = 1'b1;
    logic          powerOn = 1'b1;
    int            nFail = 0;
    int            comparisons = 0;
    logic [15:0]   rsp;

    always #5 mclk = ~mclk;

    gdfsb_status_bank #(.VARIANT_ID(VARIANT)) DUT (
        .mclk(mclk), .rst_n(rst_n), .spiIn(spi),
        .overcurrentFlags(overcurrentFlags), .gateFlags(gateFlags),
        .supplyFlags(supplyFlags), .warnFlags(warnFlags),
        .clearFaults(clearFaults), .sdo(sdo), .sdoOe_n(sdoOe_n),
        .faultInterruptPin_n(faultInterruptPin_n));
    gdfsb_spi_ctrl ctrl (.mclk(mclk), .sdo(sdo), .sdoOe_n(sdoOe_n),
                         .spiOut(spi));

    function automatic logic [7:0] exp_global();
        logic uv;
        logic ov;
        logic dsgs;
        logic tw;
        logic flt;
        uv = supplyFlags.pvddUv | supplyFlags.vcpUv;
        ov = supplyFlags.pvddOv;
        dsgs = (|overcurrentFlags) | (|gateFlags);
        tw = supplyFlags.thermalWarningFlag | (|warnFlags);
        flt = dsgs | uv | ov | supplyFlags.thermalShutdownFlag
            | supplyFlags.watchdogTimeoutFlag;
        return {linkOk, powerOn, flt, tw, dsgs, uv, ov,
                tw | supplyFlags.thermalShutdownFlag
                   | supplyFlags.watchdogTimeoutFlag};
    endfunction

    function automatic logic [7:0] exp_reg(input logic [5:0] off);
        case (off)
            `GDFSB_OFF_GLOBAL:    return exp_global();
            `GDFSB_OFF_DS_LOW:    return overcurrentFlags[15:8];
            `GDFSB_OFF_DS_HIGH:   return overcurrentFlags[7:0];
            `GDFSB_OFF_GATE_LOW:  return gateFlags[15:8];
            `GDFSB_OFF_GATE_HIGH: return gateFlags[7:0];
            `GDFSB_OFF_SUPPLY:    return {supplyFlags, ~linkOk, 1'b0};
            `GDFSB_OFF_VARIANT:   return {4'h0, VARIANT};
            default:              return 8'h00;
        endcase
    endfunction

    task automatic read_check(input logic [5:0] off);
        logic [7:0] g;
        g = exp_global();
        ctrl.frame({2'b00, off, 8'h00}, 16, rsp);
        `CHK("global", g, rsp[15:8])
        `CHK("data", exp_reg(off), rsp[7:0])
        `CHK("fault pin", ~g[5], faultInterruptPin_n)
        `CHK("enable", 1'b1, sdoOe_n)
    endtask

    task automatic sweep();
        for (int o = 0; o < 8; o++) read_check(6'(o));
        read_check(6'h3f);
    endtask

    task automatic clear_pulse();
        clearFaults = 1'b1;
        @(posedge mclk);
        #1 clearFaults = 1'b0;
        linkOk = 1'b1;
        powerOn = 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, nFail);
        if (nFail == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #300000;
        nFail++;
        tally_and_finish();
    end

    initial begin
        repeat (5) @(posedge mclk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge mclk);
        #1 sweep();
        for (int i = 0; i < 16; i++) begin
            overcurrentFlags = 16'h0001 << i;
            read_check(`GDFSB_OFF_DS_LOW + 6'(i < 8));
        end
        overcurrentFlags = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            gateFlags = 16'h0001 << i;
            read_check(`GDFSB_OFF_GATE_LOW + 6'(i < 8));
        end
        gateFlags = 16'h0000;
        for (int i = 0; i < 6; i++) begin
            supplyFlags = gdfsb_supply_t'(6'h01 << i);
            read_check(`GDFSB_OFF_SUPPLY);
        end
        supplyFlags = '0;
        for (int i = 0; i < 4; i++) begin
            warnFlags = gdfsb_warn_t'(4'h1 << i);
            read_check(`GDFSB_OFF_GLOBAL);
        end
        warnFlags = '0;
        overcurrentFlags = 16'h8001;
        ctrl.frame(16'hc1ff, 16, rsp);
        ctrl.frame(16'h41ff, 16, rsp);
        ctrl.frame(16'h80ff, 16, rsp);
        sweep();
        overcurrentFlags = 16'h0000;
        ctrl.frame(16'h0000, 15, rsp);
        linkOk = 1'b0;
        read_check(`GDFSB_OFF_SUPPLY);
        clear_pulse();
        read_check(`GDFSB_OFF_SUPPLY);
        ctrl.frame(16'h0000, 17, rsp);
        linkOk = 1'b0;
        read_check(`GDFSB_OFF_SUPPLY);
        clear_pulse();
        rst_n = 1'b0;
        repeat (5) @(posedge mclk);
        #1 rst_n = 1'b1;
        powerOn = 1'b1;
        repeat (3) @(posedge mclk);
        #1 read_check(`GDFSB_OFF_GLOBAL);
        tally_and_finish();
    end
endmodule
